// ===== design/dsg_pkg.sv
// Constants, register map and types of the deep-sleep unit clock gating block.
package dsg_pkg;

  // ---------------------------------------------------------------------------
  // Bus and address decode.
  // ---------------------------------------------------------------------------
  localparam int unsigned DSG_DATA_W   = 32;
  localparam int unsigned DSG_OFF_W    = 12;
  localparam logic [1:0]  DSG_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  DSG_HSIZE_WORD    = 3'h2;
  localparam logic        DSG_HRESP_OKAY    = 1'h0;

  // ---------------------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------------------
  localparam logic [11:0] DSG_RUN_CFG_OFF   = 12'h060;
  localparam logic [11:0] DSG_RUN_EN_OFF    = 12'h100;
  localparam logic [11:0] DSG_SLEEP_EN_OFF  = 12'h110;
  localparam logic [11:0] DSG_DEEP_EN_OFF   = 12'h120;
  localparam logic [11:0] DSG_STATUS_OFF    = 12'h124;

  // ---------------------------------------------------------------------------
  // Gating bit layout, shared by the run, sleep and deep-sleep registers.
  // ---------------------------------------------------------------------------
  localparam int unsigned DSG_UNITS         = 4;
  localparam int unsigned DSG_WATCHDOG_BIT  = 3;
  localparam int unsigned DSG_HIB_BIT       = 6;
  localparam int unsigned DSG_ADC_BIT       = 16;
  localparam int unsigned DSG_CAN_BIT       = 24;
  localparam int unsigned DSG_UNIT_BIT [DSG_UNITS] = '{DSG_WATCHDOG_BIT, DSG_HIB_BIT, DSG_ADC_BIT, DSG_CAN_BIT};
  localparam logic [31:0] DSG_GATE_MASK     = 32'h0101_0048;
  localparam logic [31:0] DSG_DEEP_RESET    = 32'h0000_0040;
  localparam logic [31:0] DSG_SLEEP_RESET   = 32'h0000_0040;
  localparam logic [31:0] DSG_RUN_RESET     = 32'h0000_0040;

  // ---------------------------------------------------------------------------
  // Run clock configuration and status layout.
  // ---------------------------------------------------------------------------
  localparam int unsigned DSG_AUTO_GATE_BIT = 27;
  localparam logic [31:0] DSG_RUN_CFG_MASK  = 32'h0800_0000;
  localparam logic [31:0] DSG_RUN_CFG_RESET = 32'h0000_0000;
  localparam int unsigned DSG_STAT_EN_LSB   = 0;
  localparam int unsigned DSG_STAT_MODE_LSB = 4;

  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_t;

endpackage

// ===== design/dsg_clock_gate.sv
// Latch-based glitch-free clock gate for one unit.
`timescale 1ns/1ns
module dsg_clock_gate (
  // Clock in.
  input  wire logic clk_in,
  // Enable, changed only after a rising edge.
  input  wire logic enable,
  // Gated clock out.
  output wire logic clk_out
);

  logic en_lat;

  // ---------------------------------------------------------------------------
  // Enable is captured while the clock is low, so a pulse is never cut short.
  // ---------------------------------------------------------------------------
  always_latch begin
    if (!clk_in) begin
      en_lat <= enable;
    end
  end

  assign clk_out = clk_in & en_lat;

endmodule

// ===== design/dsg_gating_ctrl.sv
// Unit clock gating registers with run, sleep and deep-sleep copies on an AHB-Lite slave.
`timescale 1ns/1ns
module dsg_gating_ctrl
  import dsg_pkg::*;
(
  // Clock and reset.
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave.
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Power mode requests from the core.
  input  wire logic                     sleep_req,
  input  wire logic                     deep_sleep_req,
  // Unit side: watchdog, hibernation, ADC, CAN.
  input  wire logic [dsg_pkg::DSG_UNITS-1:0] unit_access,
  output logic      [dsg_pkg::DSG_UNITS-1:0] unit_clk_en,
  output logic      [dsg_pkg::DSG_UNITS-1:0] unit_fault,
  output wire logic [dsg_pkg::DSG_UNITS-1:0] unit_clk
);

  import dsg_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode helper.
  // ---------------------------------------------------------------------------
  function automatic logic dsg_hit(input logic [11:0] addr, input logic [11:0] off);
    dsg_hit = (addr == off);
  endfunction

  // Gathers the gating bits of the units, watchdog first, from a register word.
  function automatic logic [DSG_UNITS-1:0] dsg_unit_bits(input logic [31:0] word);
    logic [DSG_UNITS-1:0] bits;
    bits = '0;
    for (int k = 0; k < DSG_UNITS; k++) begin
      bits[k] = word[DSG_UNIT_BIT[k]];
    end
    return bits;
  endfunction

  // Effective enables in reset follow the run copy, so hibernation stays clocked.
  localparam logic [DSG_UNITS-1:0] DSG_EFF_RESET = dsg_unit_bits(DSG_RUN_RESET);

  // ---------------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------------
  logic [31:0]          run_unit_clock_enables_r;
  logic [31:0]          sleep_unit_clock_enables_r;
  logic [31:0]          deep_sleep_unit_clock_enables_r;
  logic [31:0]          run_clock_configuration_r;
  logic                 wr_pend_r;
  logic [11:0]          wr_addr_r;
  logic [31:0]          hrdata_r;
  logic                 hreadyout_r;
  logic                 hresp_r;
  dsg_mode_t            mode_r;
  logic [DSG_UNITS-1:0] eff_r;
  logic [DSG_UNITS-1:0] fault_r;

  // ---------------------------------------------------------------------------
  // Address phase.
  // ---------------------------------------------------------------------------
  wire        addr_phase = hsel & (htrans == DSG_HTRANS_NONSEQ) & hready;
  wire [11:0] addr_off   = haddr[DSG_OFF_W-1:0];
  wire        wr_take    = addr_phase & hwrite & (hsize == DSG_HSIZE_WORD);
  wire        rd_take    = addr_phase & ~hwrite;

  // ---------------------------------------------------------------------------
  // Data phase writes.
  // ---------------------------------------------------------------------------
  wire wr_run_cfg = wr_pend_r & dsg_hit(wr_addr_r, DSG_RUN_CFG_OFF);
  wire wr_run     = wr_pend_r & dsg_hit(wr_addr_r, DSG_RUN_EN_OFF);
  wire wr_sleep   = wr_pend_r & dsg_hit(wr_addr_r, DSG_SLEEP_EN_OFF);
  wire wr_deep    = wr_pend_r & dsg_hit(wr_addr_r, DSG_DEEP_EN_OFF);

  wire [31:0] gate_wdata = hwdata & DSG_GATE_MASK;

  logic [31:0] run_unit_clock_enables_nxt;
  logic [31:0] sleep_unit_clock_enables_nxt;
  logic [31:0] deep_sleep_unit_clock_enables_nxt;
  logic [31:0] run_clock_configuration_nxt;

  assign run_unit_clock_enables_nxt        = wr_run ? gate_wdata : run_unit_clock_enables_r;
  assign sleep_unit_clock_enables_nxt      = wr_sleep ? gate_wdata : sleep_unit_clock_enables_r;
  assign deep_sleep_unit_clock_enables_nxt = wr_deep ? gate_wdata : deep_sleep_unit_clock_enables_r;
  assign run_clock_configuration_nxt       = wr_run_cfg ? (hwdata & DSG_RUN_CFG_MASK)
                                                        : run_clock_configuration_r;

  wire auto_gating_select = run_clock_configuration_r[DSG_AUTO_GATE_BIT];

  // ---------------------------------------------------------------------------
  // Status word.
  // ---------------------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[DSG_STAT_EN_LSB +: DSG_UNITS] = eff_r;
    status_word[DSG_STAT_MODE_LSB +: 2] = mode_r;
  end

  // ---------------------------------------------------------------------------
  // Read mux, fed from the next values so a read right after a write sees it.
  // ---------------------------------------------------------------------------
  wire hit_run_cfg = dsg_hit(addr_off, DSG_RUN_CFG_OFF);
  wire hit_run     = dsg_hit(addr_off, DSG_RUN_EN_OFF);
  wire hit_sleep   = dsg_hit(addr_off, DSG_SLEEP_EN_OFF);
  wire hit_deep    = dsg_hit(addr_off, DSG_DEEP_EN_OFF);
  wire hit_status  = dsg_hit(addr_off, DSG_STATUS_OFF);

  wire [31:0] rd_mux =
    ({32{hit_run_cfg}} & run_clock_configuration_nxt) |
    ({32{hit_run}}     & run_unit_clock_enables_nxt) |
    ({32{hit_sleep}}   & sleep_unit_clock_enables_nxt) |
    ({32{hit_deep}}    & deep_sleep_unit_clock_enables_nxt) |
    ({32{hit_status}}  & status_word);

  // ---------------------------------------------------------------------------
  // Bus slave flops.
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'h0;
    end else begin
      wr_pend_r <= wr_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_r <= 12'h000;
    end else begin
      wr_addr_r <= wr_take ? addr_off : wr_addr_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else begin
      hrdata_r <= rd_take ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'h0;
    end else begin
      hreadyout_r <= 1'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= DSG_HRESP_OKAY;
    end else begin
      hresp_r <= DSG_HRESP_OKAY;
    end
  end

  // ---------------------------------------------------------------------------
  // Gating registers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_unit_clock_enables_r <= DSG_RUN_RESET;
    end else begin
      run_unit_clock_enables_r <= run_unit_clock_enables_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_unit_clock_enables_r <= DSG_SLEEP_RESET;
    end else begin
      sleep_unit_clock_enables_r <= sleep_unit_clock_enables_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deep_sleep_unit_clock_enables_r <= DSG_DEEP_RESET;
    end else begin
      deep_sleep_unit_clock_enables_r <= deep_sleep_unit_clock_enables_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_clock_configuration_r <= DSG_RUN_CFG_RESET;
    end else begin
      run_clock_configuration_r <= run_clock_configuration_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Power mode tracking; deep-sleep takes priority over sleep.
  // ---------------------------------------------------------------------------
  dsg_mode_t mode_nxt;

  assign mode_nxt = deep_sleep_req ? DSG_MODE_DEEP :
                    sleep_req      ? DSG_MODE_SLEEP : DSG_MODE_RUN;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= DSG_MODE_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Select the gating copy in force.
  // ---------------------------------------------------------------------------
  logic [31:0] sel_word;

  always_comb begin
    case (mode_r)
      DSG_MODE_RUN: begin
        sel_word = run_unit_clock_enables_r;
      end
      DSG_MODE_SLEEP: begin
        sel_word = auto_gating_select ? sleep_unit_clock_enables_r
                                      : run_unit_clock_enables_r;
      end
      DSG_MODE_DEEP: begin
        sel_word = auto_gating_select ? deep_sleep_unit_clock_enables_r
                                      : run_unit_clock_enables_r;
      end
      default: begin
        sel_word = run_unit_clock_enables_r;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Per-unit enables, faults and clock gates.
  // ---------------------------------------------------------------------------
  logic [DSG_UNITS-1:0] eff_nxt;
  logic [DSG_UNITS-1:0] fault_nxt;

  // Bit order maps watchdog, hibernation, ADC and CAN.
  assign eff_nxt = dsg_unit_bits(sel_word);

  genvar gi;
  generate
    for (gi = 0; gi < DSG_UNITS; gi++) begin : g_unit
      assign fault_nxt[gi] = unit_access[gi] & ~eff_r[gi];

      dsg_clock_gate u_gate (
        .clk_in  (hclk),
        .enable  (eff_r[gi]),
        .clk_out (unit_clk[gi])
      );
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff_r <= DSG_EFF_RESET;
    end else begin
      eff_r <= eff_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  assign hrdata      = hrdata_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = hresp_r;
  assign unit_clk_en = eff_r;
  assign unit_fault  = fault_r;

endmodule

// ===== bench/dsg_gating_ctrl_properties.sv
// Concurrent checks on the ports of the unit clock gating block.
`timescale 1ns/1ns
module dsg_gating_ctrl_checker
  import dsg_pkg::*;
(
  // Clock and reset.
  input wire logic                              hclk,
  input wire logic                              hresetn,
  // Bus.
  input wire logic                              hsel,
  input wire logic [31:0]                       haddr,
  input wire logic [1:0]                        htrans,
  input wire logic                              hwrite,
  input wire logic                              hready,
  input wire logic [31:0]                       hrdata,
  input wire logic                              hreadyout,
  input wire logic                              hresp,
  // Modes and units.
  input wire logic                              sleep_req,
  input wire logic                              deep_sleep_req,
  input wire logic [dsg_pkg::DSG_UNITS-1:0]     unit_access,
  input wire logic [dsg_pkg::DSG_UNITS-1:0]     unit_clk_en,
  input wire logic [dsg_pkg::DSG_UNITS-1:0]     unit_fault,
  input wire logic [dsg_pkg::DSG_UNITS-1:0]     unit_clk
);
  logic        taken, act, rd_r, rdd_r, rdu_r, sl_r, dp_r;
  logic [11:0] off;
  logic [1:0]  cnt_r;
  assign taken = hsel && htrans == DSG_HTRANS_NONSEQ && hready;
  assign off   = haddr[11:0];
  assign act   = (taken && hwrite) || sleep_req != sl_r || deep_sleep_req != dp_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rd_r, rdd_r, rdu_r, sl_r, dp_r, cnt_r} <= '0;
    end else begin
      rd_r  <= taken && !hwrite;
      rdd_r <= taken && !hwrite && off == DSG_DEEP_EN_OFF;
      rdu_r <= taken && !hwrite && !(off inside {12'h060, 12'h100, 12'h110, 12'h120, 12'h124});
      sl_r  <= sleep_req;
      dp_r  <= deep_sleep_req;
      cnt_r <= act ? 2'h0 : (cnt_r == 2'h3 ? cnt_r : cnt_r + 2'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_fault; unit_fault == $past(unit_access & ~unit_clk_en); endproperty
  property p_okay; hresp == DSG_HRESP_OKAY; endproperty
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  property p_rsv; rdd_r |-> (hrdata & ~DSG_GATE_MASK) == 32'h0; endproperty
  property p_unmap; rdu_r |-> hrdata == 32'h0; endproperty
  property p_idle; !rd_r |-> hrdata == 32'h0; endproperty
  property p_gate; @(negedge hclk) unit_clk == $past(unit_clk_en); endproperty
  property p_hold; cnt_r == 2'h3 |-> $stable(unit_clk_en); endproperty
  a_fault: assert property (p_fault) else $error("unit fault does not follow gated access");
  a_okay: assert property (p_okay) else $error("register bus response not okay");
  a_ready: assert property (p_ready) else $error("ready dropped");
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  a_gate: assert property (p_gate) else $error("gated clock glitch");
  a_hold: assert property (p_hold) else $error("enables changed without cause");
  c_rd: cover property (rdd_r);
  c_fault: cover property (|unit_fault);
  c_deep: cover property (deep_sleep_req && cnt_r == 2'h3);
endmodule

bind dsg_gating_ctrl dsg_gating_ctrl_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
  .deep_sleep_req(deep_sleep_req), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
  .unit_fault(unit_fault), .unit_clk(unit_clk)
);

// ===== bench/deep_sleep_clock_gating_reg_tb.sv
// Self-checking testbench of the unit clock gating block.
`timescale 1ns/1ns
module deep_sleep_clock_gating_reg_tb;
  import dsg_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        sleep_req = 1'b0, deep_sleep_req = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hdd10b5d7, q, v;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [3:0]  unit_access = 4'h0, en;
  wire logic        hready, hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [3:0]  unit_clk_en, unit_fault, unit_clk;
  int          miscompares = 0, cmp_count = 0;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  dsg_gating_ctrl uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .unit_access(unit_access),
    .unit_clk_en(unit_clk_en), .unit_fault(unit_fault), .unit_clk(unit_clk)
  );
  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] eff(input logic [31:0] r);
    return {r[24], r[16], r[6], r[3]};
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic waitrdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t bus timeout", $time);
      stop_test;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= DSG_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= sz;
    waitrdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy;
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 3'h2);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk(unit_clk_en, 4'b0010);
    rd(12'h120, 32'h0000_0040);
    rd(12'h060, 32'h0);
    rd(12'h200, 32'h0);
    $display("test 1 done");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : seed;
      seed = lfsr(seed);
      bus(1'b1, 12'h120, v, 3'h2);
      rd(12'h120, v & 32'h0101_0048);
      chk(unit_clk_en, 4'b0010);
    end
    $display("test 2 done");
    bus(1'b1, 12'h120, 32'h0101_0000, 3'h2);
    bus(1'b1, 12'h120, 32'h0000_0048, 3'h0);
    rd(12'h120, 32'h0101_0000);
    bus(1'b1, 12'h120, q, 3'h2);
    bus(1'b1, 12'h110, 32'h0000_0008, 3'h2);
    deep_sleep_req <= 1'b1;
    settle;
    chk(unit_clk_en, 4'b0010);
    bus(1'b1, 12'h060, 32'h0800_0000, 3'h2);
    settle;
    chk(unit_clk_en, 4'b1100);
    rd(12'h124, 32'h0000_002c);
    sleep_req <= 1'b1;
    settle;
    chk(unit_clk_en, 4'b1100);
    deep_sleep_req <= 1'b0;
    settle;
    chk(unit_clk_en, 4'b0001);
    rd(12'h124, 32'h0000_0011);
    sleep_req <= 1'b0;
    settle;
    $display("test 3 done");
    for (int i = 0; i < 12; i++) begin
      v = seed;
      seed = lfsr(seed);
      bus(1'b1, 12'h100, v, 3'h2);
      rd(12'h100, v & 32'h0101_0048);
      settle;
      en = eff(v);
      chk(unit_clk_en, en);
      unit_access <= seed[3:0];
      @(posedge hclk);
      unit_access <= 4'h0;
      @(posedge hclk);
      chk(unit_fault, seed[3:0] & ~en);
      seed = lfsr(seed);
    end
    $display("test 4 done");
    stop_test;
  end
endmodule
